// File: rtl/rie_pkg.sv
/*
 * constants for the rtc interrupt status and enable block:
 * register offsets, bit positions and values after reset.
 * assumes an 8-bit register port driven by the serial front end.
 */
package rie_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_INT_EN = 8'h01;
    localparam logic [7:0] ADDR_SW_RESET = 8'h02;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_SUPPLY_SRC = 7;
    localparam int BIT_OSC_STOP = 6;
    localparam int BIT_POWER_FAIL = 5;
    localparam int BIT_TEMP_READY = 3;
    localparam int BIT_TIMER_ZERO = 2;
    localparam int BIT_SECOND_ALARM = 1;
    localparam int BIT_FIRST_ALARM = 0;
    localparam int BIT_SOFT_RESET = 0;

    // ----------------------------------------
    // values after reset and masks
    // ----------------------------------------
    localparam logic [7:0] INT_EN_RESET = 8'h00;
    localparam logic [7:0] INT_EN_WMASK = 8'h6F;
    localparam logic [7:0] IRQ_SRC_MASK = 8'h2F;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic SOFT_RESET_RESET = 1'b0;
    localparam logic [2:0] SYNC_RESET = 3'h0;

endpackage : rie_pkg

// File: rtl/rie_interrupt_status.sv
/*
 * interrupt flags, enables, software reset and the interrupt pin.
 * assumes a register port on clk from the serial front end, event
 * pulses on clk from alarm, timer and temperature logic, and three
 * analog levels that arrive asynchronously.
 */
// Overview of operation
// - status bit 7 shows main or backup supply
// - status bit 6 set while oscillator stopped
// - oscillator stop never drives the interrupt pin
// - enable bit 6 forces oscillator flag low
// - status bit 5 set on power fail
// - power fail flag holds until status read
// - enable bit 5 gates power fail interrupt
// - status bit 3 set when temperature ready
// - temperature flag with enable bit 3 interrupts
// - status bit 2 set when timer reaches zero
// - timer flag holds until status read
// - enable bit 2 gates timer interrupt
// - status bit 1 set on second alarm match
// - second alarm flag with enable bit 1 interrupts
// - enable bit 0 gates first alarm interrupt
// - alarm flags readable, cleared by status read
// - soft reset clears logic, stops oscillator
`timescale 1ns/10ps

module rie_interrupt_status (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic onBackupSupply,
    input wire logic oscStopped,
    input wire logic powerFailDetect,
    input wire logic tempReadyEvent,
    input wire logic timerZeroEvent,
    input wire logic secondAlarmEvent,
    input wire logic firstAlarmEvent,
    output logic irqOut_n,
    output logic oscEnable,
    output logic logicReset
);

    // ----------------------------------------
    // analog level synchronisers
    // ----------------------------------------
    // order: [2] supply source, [1] oscillator stop, [0] power fail
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    logic [2:0] syncC_reg;
    logic [2:0] levels_reg;
    logic [2:0] levels_next;

    // a level counts only once stages two and three agree
    always_comb
    begin
        levels_next = (syncB_reg & syncC_reg) | (levels_reg & (syncB_reg | syncC_reg));
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncA_reg <= rie_pkg::SYNC_RESET;
            syncB_reg <= rie_pkg::SYNC_RESET;
            syncC_reg <= rie_pkg::SYNC_RESET;
            levels_reg <= rie_pkg::SYNC_RESET;
        end
        else
        begin
            syncA_reg <= {onBackupSupply, oscStopped, powerFailDetect};
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            levels_reg <= levels_next;
        end
    end

    logic onBackup;
    logic oscDead;
    logic pfLevel;
    assign onBackup = levels_reg[2];
    assign oscDead = levels_reg[1];
    assign pfLevel = levels_reg[0];

    // ----------------------------------------
    // register port decode
    // ----------------------------------------
    logic statusRead;
    logic intEnWrite;
    logic swResetWrite;
    assign statusRead = regRead && (regAddr == rie_pkg::ADDR_STATUS);
    assign intEnWrite = regWrite && (regAddr == rie_pkg::ADDR_INT_EN);
    assign swResetWrite = regWrite && (regAddr == rie_pkg::ADDR_SW_RESET);

    // ----------------------------------------
    // software reset and enables
    // ----------------------------------------
    logic softReset_reg;
    logic softReset_next;
    logic [7:0] intEn_reg;
    logic [7:0] intEn_next;

    always_comb
    begin
        softReset_next = softReset_reg;
        if (swResetWrite)
        begin
            softReset_next = regWrData[rie_pkg::BIT_SOFT_RESET];
        end
        intEn_next = intEn_reg;
        if (softReset_reg)
        begin
            intEn_next = rie_pkg::INT_EN_RESET;
        end
        else if (intEnWrite)
        begin
            intEn_next = regWrData & rie_pkg::INT_EN_WMASK;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            softReset_reg <= rie_pkg::SOFT_RESET_RESET;
            intEn_reg <= rie_pkg::INT_EN_RESET;
        end
        else
        begin
            softReset_reg <= softReset_next;
            intEn_reg <= intEn_next;
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] setMask;

    // set wins over the clear of a status read in the same cycle
    always_comb
    begin
        setMask = 8'h00;
        setMask[rie_pkg::BIT_POWER_FAIL] = pfLevel;
        setMask[rie_pkg::BIT_TEMP_READY] = tempReadyEvent;
        setMask[rie_pkg::BIT_TIMER_ZERO] = timerZeroEvent;
        setMask[rie_pkg::BIT_SECOND_ALARM] = secondAlarmEvent;
        setMask[rie_pkg::BIT_FIRST_ALARM] = firstAlarmEvent;
        status_next = (statusRead ? 8'h00 : status_reg) | setMask;
        status_next[rie_pkg::BIT_SUPPLY_SRC] = onBackup;
        status_next[rie_pkg::BIT_OSC_STOP] = oscDead && !intEn_reg[rie_pkg::BIT_OSC_STOP];
        status_next[4] = 1'b0;
        if (softReset_reg)
        begin
            status_next = rie_pkg::STATUS_RESET;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_reg <= rie_pkg::STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ----------------------------------------
    // read data and output pins
    // ----------------------------------------
    logic [7:0] rdData_next;
    logic irq_next;
    logic [7:0] masked;

    // oscillator stop is left out of the source mask on purpose
    assign masked = status_reg & intEn_reg & rie_pkg::IRQ_SRC_MASK;

    always_comb
    begin
        irq_next = !(|masked);
        unique case (regAddr)
            rie_pkg::ADDR_STATUS: rdData_next = status_reg;
            rie_pkg::ADDR_INT_EN: rdData_next = intEn_reg;
            rie_pkg::ADDR_SW_RESET: rdData_next = {7'h00, softReset_reg};
            default: rdData_next = 8'h00;
        endcase
        if (!regRead)
        begin
            rdData_next = regRdData;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regRdData <= 8'h00;
            irqOut_n <= 1'b1;
            oscEnable <= 1'b1;
            logicReset <= 1'b0;
        end
        else
        begin
            regRdData <= rdData_next;
            irqOut_n <= irq_next;
            oscEnable <= !softReset_next;
            logicReset <= softReset_next;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence evSeq(logic ev);
        ev && !softReset_reg;
    endsequence

    sequence pinLowSeq;
        ##2 !irqOut_n;
    endsequence

    sequence irqClearSeq;
        ##2 irqOut_n;
    endsequence

    // a flagged source with no enabled partner anywhere in the register
    sequence quietSeq(logic src);
        src && ((status_reg & intEn_reg) == 8'h00);
    endsequence

    supply_source_a: assert property (statusRead && !$past(softReset_reg)
                                      |=> regRdData[7] == $past(onBackup, 2))
        else $error("supply source bit wrong on status read");
    osc_flag_a: assert property (evSeq(oscDead && !intEn_reg[6]) |=> status_reg[6])
        else $error("oscillator stop flag not set");
    osc_no_irq_a: assert property (quietSeq(status_reg[6]) |=> irqOut_n)
        else $error("interrupt pin driven without enabled source");
    osc_disable_a: assert property (intEn_reg[6] && !softReset_reg |=> !status_reg[6])
        else $error("oscillator flag not forced low");
    power_fail_flag_set_a: assert property (evSeq(pfLevel) |=> status_reg[5])
        else $error("power fail flag not set");
    power_fail_flag_hold_a: assert property (status_reg[5] && !statusRead && !softReset_reg |=> status_reg[5])
        else $error("power fail flag lost without read");
    power_fail_flag_irq_a: assert property (evSeq(pfLevel && intEn_reg[5] && !intEnWrite)
                                  ##1 !softReset_reg |-> ##1 !irqOut_n)
        else $error("power fail interrupt missing");
    temp_irq_a: assert property (evSeq(tempReadyEvent && intEn_reg[3] && !intEnWrite) |-> pinLowSeq)
        else $error("temperature interrupt missing");
    timer_irq_a: assert property (evSeq(timerZeroEvent && intEn_reg[2] && !intEnWrite) |-> pinLowSeq)
        else $error("timer interrupt missing");
    alarm_clear_a: assert property (statusRead && !secondAlarmEvent && !firstAlarmEvent
                                    |=> status_reg[1:0] == 2'h0)
        else $error("alarm flags not cleared by status read");
    irq_or_a: assert property (irqOut_n == !(|($past(status_reg) & $past(intEn_reg) & 8'h2F)))
        else $error("interrupt pin differs from enabled flags");
    soft_reset_a: assert property (swResetWrite && regWrData[0] |=> !oscEnable ##1 intEn_reg == 8'h00)
        else $error("soft reset did not clear logic");

    // ----------------------------------------
    // flag set, hold and clear checks, enable mask and read data hold
    // ----------------------------------------
    // pulses are not stretched, so a flag must catch the very next edge
    temp_set_a: assert property (evSeq(tempReadyEvent) |=> status_reg[3])
        else $error("temperature ready flag not set");
    timer_set_a: assert property (evSeq(timerZeroEvent) |=> status_reg[2])
        else $error("timer flag not set");
    timer_hold_a: assert property (status_reg[2] && !statusRead && !softReset_reg |=> status_reg[2])
        else $error("timer flag lost without read");
    timer_clear_a: assert property (statusRead && !timerZeroEvent |=> !status_reg[2])
        else $error("timer flag not cleared by status read");
    alarm2_set_a: assert property (evSeq(secondAlarmEvent) |=> status_reg[1])
        else $error("second alarm flag not set");
    alarm1_set_a: assert property (evSeq(firstAlarmEvent) |=> status_reg[0])
        else $error("first alarm flag not set");
    en_mask_a: assert property (intEnWrite && !softReset_reg |=> intEn_reg == ($past(regWrData) & 8'h6F))
        else $error("enable write not taken as masked");
    rd_hold_a: assert property (!regRead |=> $stable(regRdData))
        else $error("read data changed without a read");

    // ----------------------------------------
    // pin and soft reset checks
    // ----------------------------------------
    alarm2_irq_a: assert property (evSeq(secondAlarmEvent && intEn_reg[1] && !intEnWrite) |-> pinLowSeq)
        else $error("second alarm interrupt missing");
    alarm1_irq_a: assert property (evSeq(firstAlarmEvent && intEn_reg[0] && !intEnWrite) |-> pinLowSeq)
        else $error("first alarm interrupt missing");
    pf_quiet_a: assert property (quietSeq(status_reg[5] && !intEn_reg[5]) |=> irqOut_n)
        else $error("masked power fail drove the interrupt pin");
    timer_quiet_a: assert property (quietSeq(status_reg[2] && !intEn_reg[2]) |=> irqOut_n)
        else $error("masked timer flag drove the interrupt pin");
    irq_clear_a: assert property (statusRead && !pfLevel && !tempReadyEvent && !timerZeroEvent
                                  && !secondAlarmEvent && !firstAlarmEvent |-> irqClearSeq)
        else $error("interrupt pin held after flags cleared");
    soft_hold_a: assert property (softReset_reg |=> status_reg == 8'h40 && intEn_reg == 8'h00)
        else $error("soft reset did not hold status and enables");
    osc_pin_a: assert property (oscEnable != softReset_reg && logicReset == softReset_reg)
        else $error("oscillator enable differs from soft reset bit");

endmodule : rie_interrupt_status

// File: testbench/rie_host_model.sv
/*
 * host model: master of the register port, with write and read tasks.
 * assumes clk from the bench and a design that samples on the rising edge.
 */
`timescale 1ns/10ps

module rie_host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 8'h00;
    end

    // released lines show the inverse, so stale values never match by luck
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regWrData = ~d;
        regAddr = ~a;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask : rd
endmodule : rie_host_model

// File: testbench/rtc_interrupt_status_enable_tb.sv
/*
 * self-checking bench: event table, then power fail, oscillator, supply,
 * masks and soft reset by hand. assumes rie_pkg and the host model.
 */
`timescale 1ns/10ps

module rtc_interrupt_status_enable_tb;
    typedef struct packed {logic [3:0] ev; logic [7:0] en; logic irqN;} rie_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr, regWrData, regRdData, d;
    logic regWrite, regRead, irqOut_n, oscEnable, logicReset;
    logic bak = 1'b0, osc = 1'b0, pf = 1'b0;
    logic [3:0] ev = 4'h0;
    int n_errors = 0;
    int comparisons = 0;
    rie_row_t rows [7] = '{'{4'h8, 8'h08, 1'b0}, '{4'h8, 8'h00, 1'b1}, '{4'h4, 8'h04, 1'b0},
        '{4'h4, 8'h00, 1'b1}, '{4'h2, 8'h02, 1'b0}, '{4'h1, 8'h01, 1'b0}, '{4'h1, 8'h02, 1'b1}};

    always #20 clk = ~clk;

    rie_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData));

    rie_interrupt_status dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData), .onBackupSupply(bak),
        .oscStopped(osc), .powerFailDetect(pf), .tempReadyEvent(ev[3]), .timerZeroEvent(ev[2]),
        .secondAlarmEvent(ev[1]), .firstAlarmEvent(ev[0]), .irqOut_n(irqOut_n),
        .oscEnable(oscEnable), .logicReset(logicReset));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        cyc(1);
        chk("rd reset", 8'h00, regRdData);
        chk("irq reset", 8'h01, {7'h00, irqOut_n});
        chk("osc reset", 8'h01, {7'h00, oscEnable});
        chk("soft reset", 8'h00, {7'h00, logicReset});
        cyc(1);
        reset_n = 1'b1;
        cyc(8);
        host.rd(rie_pkg::ADDR_INT_EN, d);
        chk("enable after reset", rie_pkg::INT_EN_RESET, d);
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("status idle", 8'h00, d);
        $display("test reset done");
        foreach (rows[i])
        begin
            host.wr(rie_pkg::ADDR_INT_EN, rows[i].en);
            ev = rows[i].ev;
            cyc(1);
            ev = 4'h0;
            cyc(1);
            chk("irq set", {7'h00, rows[i].irqN}, {7'h00, irqOut_n});
            host.rd(rie_pkg::ADDR_STATUS, d);
            chk("status flag", {4'h0, rows[i].ev}, d);
            cyc(1);
            chk("irq clear", 8'h01, {7'h00, irqOut_n});
        end
        $display("test events done");
        host.wr(rie_pkg::ADDR_INT_EN, 8'h00);
        pf = 1'b1;
        cyc(8);
        chk("pf masked irq", 8'h01, {7'h00, irqOut_n});
        host.wr(rie_pkg::ADDR_INT_EN, 8'h20);
        cyc(1);
        chk("pf irq", 8'h00, {7'h00, irqOut_n});
        pf = 1'b0;
        cyc(8);
        chk("pf sticky irq", 8'h00, {7'h00, irqOut_n});
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("pf status", 8'h20, d);
        cyc(1);
        chk("pf cleared irq", 8'h01, {7'h00, irqOut_n});
        host.wr(rie_pkg::ADDR_INT_EN, 8'hFF);
        host.rd(rie_pkg::ADDR_INT_EN, d);
        chk("enable mask", rie_pkg::INT_EN_WMASK, d);
        host.wr(rie_pkg::ADDR_INT_EN, 8'h2F);
        osc = 1'b1;
        cyc(8);
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("osc flag", 8'h40, d);
        chk("osc no irq", 8'h01, {7'h00, irqOut_n});
        host.wr(rie_pkg::ADDR_INT_EN, 8'h40);
        cyc(2);
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("osc flag off", 8'h00, d);
        osc = 1'b0;
        bak = 1'b1;
        cyc(8);
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("backup supply", 8'h80, d);
        bak = 1'b0;
        cyc(8);
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("main supply", 8'h00, d);
        host.rd(8'h05, d);
        chk("unmapped", 8'h00, d);
        $display("test levels done");
        host.wr(rie_pkg::ADDR_INT_EN, 8'h05);
        host.wr(rie_pkg::ADDR_SW_RESET, 8'h01);
        cyc(2);
        chk("osc off", 8'h00, {7'h00, oscEnable});
        chk("soft active", 8'h01, {7'h00, logicReset});
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("status in soft reset", rie_pkg::STATUS_RESET, d);
        host.wr(rie_pkg::ADDR_INT_EN, 8'h0F);
        host.rd(rie_pkg::ADDR_INT_EN, d);
        chk("enable cleared", 8'h00, d);
        host.rd(rie_pkg::ADDR_SW_RESET, d);
        chk("reset bit kept", 8'h01, d);
        host.wr(rie_pkg::ADDR_SW_RESET, 8'h00);
        cyc(2);
        chk("osc back", 8'h01, {7'h00, oscEnable});
        chk("soft left", 8'h00, {7'h00, logicReset});
        $display("test soft reset done");
        host.wr(rie_pkg::ADDR_INT_EN, 8'h04);
        ev = 4'h4;
        cyc(1);
        ev = 4'h0;
        cyc(1);
        chk("irq before reset", 8'h00, {7'h00, irqOut_n});
        reset_n = 1'b0;
        cyc(2);
        chk("irq in reset", 8'h01, {7'h00, irqOut_n});
        chk("rd in reset", 8'h00, regRdData);
        reset_n = 1'b1;
        cyc(2);
        host.rd(rie_pkg::ADDR_INT_EN, d);
        chk("enable after mid reset", rie_pkg::INT_EN_RESET, d);
        host.rd(rie_pkg::ADDR_STATUS, d);
        chk("status after mid reset", 8'h00, d);
        $display("test mid reset done");
        results();
    end

    // hang guard
    initial
    begin
        #400000;
        n_errors++;
        results();
    end
endmodule : rtc_interrupt_status_enable_tb
